// ==== src/acsq_top.sv ====
// Conversion control and channel sequencer of an eight-channel SAR converter.
// Assumes the trigger and conversion clock are asynchronous pins and the
// register port is driven from the CLK_SYS domain.

// Function
// - Shadow mode sequences channels with set bits
// - Lowest selected channel first, then ascending
// - Wrap to first selected channel, repeat
// - Write with code 1,0 keeps sequence running
// - Other code written ends running sequence
// - Consecutive mode counts zero to address
// - Consecutive mode starts channel zero immediately
// - Reference bit one selects internal reference
// - Trigger fall starts conversion, busy high
// - Early trigger rise aborts, back to track
// - Busy falls when conversion completes
// - Powerup hold until first trigger rise
// - Hold on fall, track at 13th rise
// - Auto power modes wake on trigger rise
// - Data width 12 or 10, word/byte
// - Plain mode address selects next channel
module acsq_top
   import acsq_pkg::*;
#(
   parameter int DATA_BITS = 12
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output logic      [31:0] RDATA,
   input  wire logic        CONVERSION_TRIGGER_N,
   input  wire logic        CONVERSION_CLOCK_INPUT,
   output logic             BUSY,
   output logic             TRACK,
   output logic      [2:0]  MUX_CHANNEL,
   output logic             REF_INTERNAL,
   output logic             POWERED,
   output logic             WORD_MODE,
   output logic      [3:0]  DATA_WIDTH,
   output logic             IRQ
);

   // ****************************************
   // Helper functions
   // ****************************************
   // Lowest set bit at or above start, wrapping; start if none set
   function automatic logic [2:0] next_set(input logic [7:0] mask, input logic [2:0] start);
      logic [2:0] res;
      logic       found;
      logic [2:0] idx;
      res   = start;
      found = 1'b0;
      for (int i = 0; i < 8; i++) begin
         idx = start + i[2:0];
         if (!found && mask[idx]) begin
            res   = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction : next_set

   function automatic logic agree_edge(input logic [2:0] s, input logic lvl);
      return (s[2] == lvl) && (s[1] == lvl);
   endfunction : agree_edge

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] trig_sync_reg;
   logic [2:0] cclk_sync_reg;
   logic       trig_lvl_reg;
   logic       cclk_lvl_reg;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         trig_sync_reg <= 3'h7;
         cclk_sync_reg <= 3'h0;
      end else begin
         trig_sync_reg <= {trig_sync_reg[1:0], CONVERSION_TRIGGER_N};
         cclk_sync_reg <= {cclk_sync_reg[1:0], CONVERSION_CLOCK_INPUT};
      end
   end

   // Level changes only when the last two stages agree
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         trig_lvl_reg <= 1'b1;
         cclk_lvl_reg <= 1'b0;
      end else begin
         if (agree_edge(trig_sync_reg, ~trig_lvl_reg)) begin
            trig_lvl_reg <= ~trig_lvl_reg;
         end
         if (agree_edge(cclk_sync_reg, ~cclk_lvl_reg)) begin
            cclk_lvl_reg <= ~cclk_lvl_reg;
         end
      end
   end

   logic trig_fall;
   logic trig_rise;
   logic cclk_rise;
   logic cclk_fall;
   assign trig_fall = trig_lvl_reg && agree_edge(trig_sync_reg, 1'b0);
   assign trig_rise = !trig_lvl_reg && agree_edge(trig_sync_reg, 1'b1);
   assign cclk_rise = !cclk_lvl_reg && agree_edge(cclk_sync_reg, 1'b1);
   assign cclk_fall = cclk_lvl_reg && agree_edge(cclk_sync_reg, 1'b0);

   // ****************************************
   // Registers
   // ****************************************
   logic [8:0]           ctrl_reg;
   logic [7:0]           shadow_reg;
   logic [IRQ_WIDTH-1:0] irq_stat_reg;
   logic [IRQ_WIDTH-1:0] irq_mask_reg;
   logic                 ctrl_wr;
   logic                 keep_code;
   logic [1:0]           seq_code;
   assign ctrl_wr   = WR_STB && (ADDR == ADDR_CTRL);
   assign seq_code  = {WDATA[CTRL_SEQ_BIT], WDATA[CTRL_SHADOW_SELECT_BIT_BIT]};
   assign keep_code = (seq_code == 2'b10);

   // A keep-code write updates the other fields, power mode included, but not the sequence and shadow select bits or the address bits
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg <= WDATA[8:0];
         if (keep_code) begin
            ctrl_reg[CTRL_SEQ_BIT]  <= ctrl_reg[CTRL_SEQ_BIT];
            ctrl_reg[CTRL_SHADOW_SELECT_BIT_BIT] <= ctrl_reg[CTRL_SHADOW_SELECT_BIT_BIT];
            ctrl_reg[2:0]           <= ctrl_reg[2:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         shadow_reg <= SHADOW_RESET;
      end else if (WR_STB && ADDR == ADDR_SHADOW) begin
         shadow_reg <= WDATA[7:0];
      end
   end

   // ****************************************
   // Sequencer pointer
   // ****************************************
   logic [2:0] chan_reg;
   logic       conv_done;
   logic       seq_shadow;
   logic       seq_consec;
   assign seq_shadow = !ctrl_reg[CTRL_SEQ_BIT] && ctrl_reg[CTRL_SHADOW_SELECT_BIT_BIT];
   assign seq_consec = ctrl_reg[CTRL_SEQ_BIT] && ctrl_reg[CTRL_SHADOW_SELECT_BIT_BIT];

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         chan_reg <= 3'h0;
      end else if (ctrl_wr && !keep_code) begin
         if (seq_code == 2'b11) begin
            chan_reg <= 3'h0;
         end else if (seq_code == 2'b01) begin
            chan_reg <= next_set(shadow_reg, 3'h0);
         end else begin
            chan_reg <= WDATA[2:0];
         end
      end else if (WR_STB && ADDR == ADDR_SHADOW && seq_shadow) begin
         chan_reg <= next_set(WDATA[7:0], 3'h0);
      end else if (conv_done) begin
         if (seq_shadow) begin
            chan_reg <= next_set(shadow_reg, chan_reg + 3'h1);
         end else if (seq_consec) begin
            chan_reg <= (chan_reg >= ctrl_reg[2:0]) ? 3'h0 : chan_reg + 3'h1;
         end
      end
   end

   // ****************************************
   // Conversion state machine
   // ****************************************
   acsq_state_e state_reg;
   logic [4:0]  rise_cnt_reg;
   logic [4:0]  fall_cnt_reg;
   logic        abort_evt;
   logic        auto_pm;
   assign auto_pm   = (ctrl_reg[CTRL_PM_LSB +: 2] == PM_AUTOSHUT)
                   || (ctrl_reg[CTRL_PM_LSB +: 2] == PM_AUTOSTBY);
   assign conv_done = (state_reg == ACSQ_CONVERT) && cclk_fall
                   && (fall_cnt_reg == DONE_FALL_EDGES - 5'h1);
   assign abort_evt = (state_reg == ACSQ_CONVERT) && trig_rise && !conv_done;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_reg <= ACSQ_POWERUP;
      end else begin
         case (state_reg)
            ACSQ_POWERUP: if (trig_rise) state_reg <= ACSQ_TRACK;
            ACSQ_TRACK:   if (trig_fall) state_reg <= ACSQ_CONVERT;
            ACSQ_CONVERT: begin
               if (conv_done) begin
                  state_reg <= auto_pm ? ACSQ_SHUT : ACSQ_TRACK;
               end else if (abort_evt) begin
                  state_reg <= ACSQ_TRACK;
               end
            end
            ACSQ_SHUT:    if (trig_rise) state_reg <= ACSQ_TRACK;
            default:      state_reg <= ACSQ_POWERUP;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || state_reg != ACSQ_CONVERT) begin
         rise_cnt_reg <= 5'h0;
         fall_cnt_reg <= 5'h0;
      end else begin
         if (cclk_rise && rise_cnt_reg != 5'h1F) rise_cnt_reg <= rise_cnt_reg + 5'h1;
         if (cclk_fall) fall_cnt_reg <= fall_cnt_reg + 5'h1;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Busy stands from the trigger fall until done or abort
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         BUSY <= 1'b0;
      end else if (state_reg == ACSQ_CONVERT) begin
         BUSY <= !(conv_done || abort_evt);
      end else begin
         BUSY <= (state_reg == ACSQ_TRACK) && trig_fall;
      end
   end

   // Hold from the trigger fall; track again from the 13th rise onwards
   logic hold_end;
   assign hold_end = cclk_rise && (rise_cnt_reg == HOLD_RISE_EDGES - 5'h1);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         TRACK <= 1'b0;
      end else if (state_reg == ACSQ_TRACK && trig_fall) begin
         TRACK <= 1'b0;
      end else if (state_reg == ACSQ_CONVERT) begin
         if (abort_evt) begin
            TRACK <= 1'b1;
         end else if (conv_done) begin
            TRACK <= !auto_pm;
         end else begin
            TRACK <= TRACK || hold_end;
         end
      end else begin
         TRACK <= (state_reg == ACSQ_TRACK) || trig_rise;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         MUX_CHANNEL <= 3'h0;
      end else begin
         MUX_CHANNEL <= chan_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         REF_INTERNAL <= 1'b0;
      end else begin
         REF_INTERNAL <= ctrl_reg[CTRL_REF_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         POWERED <= 1'b1;
      end else begin
         POWERED <= (state_reg != ACSQ_SHUT) || trig_rise;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         WORD_MODE <= 1'b0;
      end else begin
         WORD_MODE <= ctrl_reg[CTRL_WORD_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         DATA_WIDTH <= 4'h0;
      end else begin
         DATA_WIDTH <= DATA_BITS[3:0];
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   logic [IRQ_WIDTH-1:0] irq_set;
   assign irq_set = {abort_evt, conv_done};

   // A new event wins over a write-one clear in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_stat_reg <= '0;
      end else if (WR_STB && ADDR == ADDR_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~WDATA[IRQ_WIDTH-1:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_mask_reg <= '0;
      end else if (WR_STB && ADDR == ADDR_IRQ_MASK) begin
         irq_mask_reg <= WDATA[IRQ_WIDTH-1:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) IRQ <= 1'b0;
      else     IRQ <= |(irq_stat_reg & irq_mask_reg);
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RDATA <= 32'h0;
      end else if (RD_STB) begin
         case (ADDR)
            ADDR_CTRL:     RDATA <= {23'h0, ctrl_reg};
            ADDR_SHADOW:   RDATA <= {24'h0, shadow_reg};
            ADDR_STATUS:   RDATA <= {25'h0, chan_reg, state_reg, TRACK, BUSY};
            ADDR_IRQ_STAT: RDATA <= {30'h0, irq_stat_reg};
            ADDR_IRQ_MASK: RDATA <= {30'h0, irq_mask_reg};
            default:       RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end

endmodule : acsq_top

// ==== pkg/acsq_pkg.sv ====
// Constants for the converter sequencer and conversion control block.
// Assumes a single 125 MHz system clock and a plain register port.
package acsq_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_SHADOW     = 4'h4;
   localparam logic [3:0]  ADDR_STATUS     = 4'h8;
   localparam logic [3:0]  ADDR_IRQ_STAT   = 4'hC;
   localparam logic [3:0]  ADDR_IRQ_MASK   = 4'hE;

   // ****************************************
   // Control word fields
   // ****************************************
   localparam int          CTRL_ADDR_LSB   = 0;
   localparam int          CTRL_SHADOW_SELECT_BIT_BIT   = 3;
   localparam int          CTRL_SEQ_BIT    = 4;
   localparam int          CTRL_REF_BIT    = 5;
   localparam int          CTRL_PM_LSB     = 6;
   localparam int          CTRL_WORD_BIT   = 8;
   localparam logic [8:0]  CTRL_RESET      = 9'h000;
   localparam logic [7:0]  SHADOW_RESET    = 8'h00;

   // ****************************************
   // Power modes
   // ****************************************
   localparam logic [1:0]  PM_NORMAL       = 2'h0;
   localparam logic [1:0]  PM_AUTOSHUT     = 2'h1;
   localparam logic [1:0]  PM_AUTOSTBY     = 2'h2;

   // ****************************************
   // Interrupt bits
   // ****************************************
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_ABORT       = 1;
   localparam int          IRQ_WIDTH       = 2;

   // ****************************************
   // Conversion timing in input-clock edges
   // ****************************************
   localparam logic [4:0]  HOLD_RISE_EDGES = 5'h0D;
   localparam logic [4:0]  DONE_FALL_EDGES = 5'h0E;

   typedef enum logic [1:0] {
      ACSQ_POWERUP = 2'b00,
      ACSQ_TRACK   = 2'b01,
      ACSQ_CONVERT = 2'b10,
      ACSQ_SHUT    = 2'b11
   } acsq_state_e;

endpackage : acsq_pkg

// ==== verification/acsq_props.sv ====
// Checker for the converter sequencer and conversion control block.
// Assumes it is bound to acsq_top and sees only that module's ports.
module acsq_props
   import acsq_pkg::*;
#(
   parameter int DATA_BITS = 12
) (
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic [3:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR_STB,
   input wire logic        RD_STB,
   input wire logic [31:0] RDATA,
   input wire logic        CONVERSION_TRIGGER_N,
   input wire logic        BUSY,
   input wire logic        TRACK,
   input wire logic [2:0]  MUX_CHANNEL,
   input wire logic        REF_INTERNAL,
   input wire logic        POWERED,
   input wire logic [3:0]  DATA_WIDTH
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   // Idle control write carrying the given sequence and shadow code
   sequence s_ctrl_wr(logic [1:0] m);
      WR_STB && ADDR == ADDR_CTRL && !BUSY
         && {WDATA[CTRL_SEQ_BIT], WDATA[CTRL_SHADOW_SELECT_BIT_BIT]} == m;
   endsequence

   chk_busy_start: assert property (
      $fell(CONVERSION_TRIGGER_N) && TRACK && !BUSY && POWERED |-> ##[1:6] BUSY)
      else $error("busy did not follow trigger fall");
   chk_hold_start: assert property (
      $rose(BUSY) |-> !CONVERSION_TRIGGER_N ##[0:1] !TRACK)
      else $error("no hold at conversion start");
   chk_track_end: assert property (
      $fell(BUSY) |-> ##[0:1] (TRACK || !POWERED))
      else $error("no track after conversion end");
   chk_rdata_idle: assert property (!$past(RD_STB) |-> RDATA == 32'h0)
      else $error("read data outside read cycle");
   chk_width_fixed: assert property (
      !$past(RST) |-> DATA_WIDTH == 4'(DATA_BITS))
      else $error("data width wrong");
   chk_ref_follow: assert property (
      WR_STB && ADDR == ADDR_CTRL |-> ##2 REF_INTERNAL == $past(WDATA[CTRL_REF_BIT], 2))
      else $error("reference select wrong");
   chk_plain_mux: assert property (
      s_ctrl_wr(2'b00) |-> ##2 MUX_CHANNEL == $past(WDATA[2:0], 2))
      else $error("plain channel not selected");
   chk_consec_zero: assert property (
      s_ctrl_wr(2'b11) |-> ##2 MUX_CHANNEL == 3'h0)
      else $error("consecutive run not at channel zero");
   chk_keep_mux: assert property (
      s_ctrl_wr(2'b10) |=> $stable(MUX_CHANNEL))
      else $error("keep code disturbed channel");
   chk_mux_step: assert property (
      $changed(MUX_CHANNEL) |-> $past(WR_STB, 2) || ($past(BUSY, 2) && !BUSY))
      else $error("channel moved without cause");
endmodule : acsq_props

bind acsq_top acsq_props #(.DATA_BITS(DATA_BITS)) i_props (
   .CLK_SYS(CLK_SYS),
   .RST(RST),
   .ADDR(ADDR),
   .WDATA(WDATA),
   .WR_STB(WR_STB),
   .RD_STB(RD_STB),
   .RDATA(RDATA),
   .CONVERSION_TRIGGER_N(CONVERSION_TRIGGER_N),
   .BUSY(BUSY),
   .TRACK(TRACK),
   .MUX_CHANNEL(MUX_CHANNEL),
   .REF_INTERNAL(REF_INTERNAL),
   .POWERED(POWERED),
   .DATA_WIDTH(DATA_WIDTH)
);

// ==== verification/acsq_host.sv ====
// Host model: free input clock and conversion trigger strobes.
// Assumes go is a one-cycle request on clk, taken only while idle.
module acsq_host (
   output logic      trigger_n,
   output logic      conv_clk,
   output logic      idle,
   input  wire logic clk,
   input  wire logic go,
   input  wire logic early
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      trigger_n = 1'b0;
      conv_clk  = 1'b0;
      idle      = 1'b1;
      forever #64 conv_clk = ~conv_clk;
   end

   always @(posedge clk) begin
      if (go) begin
         idle      <= 1'b0;
         trigger_n <= 1'b1;
         repeat (16) @(posedge clk);
         trigger_n <= 1'b0;
         repeat (early ? 5 : 16) @(negedge conv_clk);
         // Early release aborts; a full conversion leaves the trigger low
         if (early) begin
            trigger_n <= 1'b1;
         end
         repeat (8) @(posedge clk);
         idle <= 1'b1;
      end
   end
endmodule : acsq_host

// ==== verification/adc_channel_sequencer_conversion_control_test.sv ====
// Self-checking bench for the sequencer and conversion control block.
// Assumes acsq_top, the checker and the host model are compiled first.
module adc_channel_sequencer_conversion_control_test
   import acsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DATA_BITS = 12;
   logic        clk_sys, rst, wr_stb, rd_stb, go, early, trig_n, cclk, idle;
   logic        busy, track, ref_int, powered, word, irq;
   logic [3:0]  addr, width;
   logic [31:0] wdata, rdata;
   logic [2:0]  mux;
   logic [2:0]  shd_tbl [4] = '{3'h5, 3'h7, 3'h2, 3'h5};
   int          errors  = 0;
   int          n_tests = 0;

   acsq_top #(.DATA_BITS(DATA_BITS)) i_dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
      .CONVERSION_TRIGGER_N(trig_n), .CONVERSION_CLOCK_INPUT(cclk), .BUSY(busy),
      .TRACK(track), .MUX_CHANNEL(mux), .REF_INTERNAL(ref_int), .POWERED(powered),
      .WORD_MODE(word), .DATA_WIDTH(width), .IRQ(irq));
   acsq_host i_host (.trigger_n(trig_n), .conv_clk(cclk), .idle(idle), .clk(clk_sys),
      .go(go), .early(early));

   task automatic end_of_test();
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Write, then one more cycle so registered outputs settle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rd_chk

   task automatic conv(input logic e);
      int i = 0;
      early <= e;
      go    <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (12) @(posedge clk_sys);
      chk(32'(track), 32'h1);
      chk(32'(powered), 32'h1);
      repeat (28) @(posedge clk_sys);
      chk(32'(busy), 32'h1);
      chk(32'(track), 32'h0);
      while (idle !== 1'b1 && i < 1000) begin
         @(posedge clk_sys);
         i++;
      end
      if (i >= 1000) begin
         errors++;
         $display("unexpected at %0t: host timeout", $time);
         end_of_test();
      end
      #1;
   endtask : conv

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      rst    = 1'b1;
      addr   = 4'h0;
      wdata  = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      go     = 1'b0;
      early  = 1'b0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(32'(track), 32'h0);
      chk(32'(width), 32'(DATA_BITS));
      wr(ADDR_CTRL, 32'h125);
      chk(32'(mux), 32'h5);
      chk(32'(ref_int), 32'h1);
      chk(32'(word), 32'h1);
      conv(1'b0);
      chk(32'(busy), 32'h0);
      chk(32'(mux), 32'h5);
      wr(ADDR_STATUS, 32'hFFFFFFFF);
      rd_chk(ADDR_STATUS, {25'h0, 3'h5, ACSQ_TRACK, 2'h2});
      rd_chk(4'h2, 32'h0);
      rd_chk(ADDR_IRQ_STAT, 32'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      conv(1'b1);
      chk(32'(busy), 32'h0);
      chk(32'(track), 32'h1);
      rd_chk(ADDR_IRQ_STAT, 32'h2);
      wr(ADDR_IRQ_STAT, 32'h3);
      wr(ADDR_CTRL, 32'h008);
      chk(32'(ref_int), 32'h0);
      wr(ADDR_SHADOW, 32'h0A4);
      chk(32'(mux), 32'h2);
      for (int k = 0; k < 4; k++) begin
         if (k == 2) begin
            wr(ADDR_CTRL, 32'h010);
            chk(32'(mux), 32'h7);
         end
         conv(1'b0);
         chk(32'(mux), 32'(shd_tbl[k]));
      end
      wr(ADDR_CTRL, 32'h003);
      chk(32'(mux), 32'h3);
      wr(ADDR_CTRL, 32'h01A);
      chk(32'(mux), 32'h0);
      for (int k = 0; k < 3; k++) begin
         conv(1'b0);
         chk(32'(mux), 32'((k + 1) % 3));
      end
      wr(ADDR_CTRL, 32'h040);
      conv(1'b0);
      chk(32'(powered), 32'h0);
      conv(1'b0);
      wr(ADDR_IRQ_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      wr(ADDR_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h0);
      end_of_test();
   end
endmodule : adc_channel_sequencer_conversion_control_test
